// >>> rtl/tks_counter.sv
// saturating event counter with synchronous clear
// assumes inc is a one-cycle pulse per counted oscillator edge
`timescale 1ns/10ps
module tks_counter #(
  parameter int W = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // control
  input wire logic clear,
  input wire logic inc,
  // value
  output logic [W-1:0] count
);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  // saturation keeps a too-fast oscillator from wrapping to a small count
  always_comb begin
    count_next = count_reg;
    if (clear) begin
      count_next = '0;
    end else if (inc && (count_reg != {W{1'b1}})) begin
      count_next = count_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count = count_reg;

endmodule : tks_counter

// >>> rtl/tks_pkg.sv
// touch-key scan control: register map, field positions, reset values, timing
// assumes an 8-bit register port addressed by the printed register offsets
package tks_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] TKS_OFS_IRQ_FLAGS = 8'h95;
  localparam logic [7:0] TKS_OFS_SHARED_DATA = 8'hAA;
  localparam logic [7:0] TKS_OFS_COUNT_LOW = 8'hAC;
  localparam logic [7:0] TKS_OFS_OSC_TRIM = 8'hAD;
  localparam logic [7:0] TKS_OFS_CONTROL = 8'hAE;
  localparam logic [7:0] TKS_OFS_WINDOW_LOW = 8'hB4;
  localparam logic [7:0] TKS_OFS_CONTROL2 = 8'hB5;
  localparam logic [7:0] TKS_OFS_AUX_CONTROL_ONE = 8'hF8;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int TKS_IRQ_FLAG_BIT = 5;
  localparam int TKS_START_BIT = 5;
  localparam int TKS_PD_BIT = 7;
  localparam int TKS_EOC_BIT = 6;
  localparam int TKS_AUTO_BIT = 7;
  localparam int TKS_FINE_LSB = 4;
  localparam int TKS_FINE_W = 3;
  localparam int TKS_CHAN_W = 4;
  localparam int TKS_WINH_W = 4;
  localparam int TKS_TRIM_W = 7;
  localparam int TKS_COUNT_W = 12;
  localparam int TKS_WINDOW_W = 12;
  localparam int TKS_KEYS = 16;

  // value whose write to the flag register clears the touch flag
  localparam logic [7:0] TKS_IRQ_CLEAR_CODE = 8'hDF;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [6:0] TKS_TRIM_RST = 7'h40;
  localparam logic [3:0] TKS_CHAN_RST = 4'hF;
  localparam logic [7:0] TKS_WINL_RST = 8'hFF;
  localparam logic [3:0] TKS_WINH_RST = 4'h0;
  localparam logic [2:0] TKS_FINE_RST = 3'h4;
  localparam logic TKS_PD_RST = 1'b1;
  localparam logic [2:0] TKS_FINE_SLOW = 3'h0;
  localparam logic [2:0] TKS_FINE_FAST = 3'h7;

  // ****************************************************************
  // timing: end flag may lag the start by this long (firmware side)
  // ****************************************************************
  localparam int TKS_CLK_MHZ = 40;
  localparam int TKS_EOC_LAG_NS = 3000;
  localparam int TKS_EOC_LAG_CYC = (TKS_EOC_LAG_NS * TKS_CLK_MHZ + 999) / 1000;

  // ****************************************************************
  // conversion sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {
    TKS_IDLE = 2'b01,
    TKS_RUN = 2'b10
  } tks_state_e;

endpackage : tks_pkg

// >>> rtl/tks_scan_ctrl.sv
// touch-key scan control: registers, conversion sequencer, counters
// assumes reference_osc and touch_osc are free-running oscillator levels
// well below half of clk, and an 8-bit register port with one-cycle strobes
//
// Overview of operation
// (RULE1) conversion end sets touch interrupt flag
// (RULE2) flag clears on DFh write or start
// (RULE3) count result readable, high nibble and low byte
// (RULE4) seven-bit oscillator trim, reset 40h
// (RULE5) firmware picks trim for expected count ratio
// (RULE6) power-down bit disables module, resets high
// (RULE7) end flag low while converting, high done
// (RULE8) firmware waits before polling end flag
// (RULE9) channel select keys 0-14, 1111 internal; the code connects key 15 for 1111
// (RULE10) twelve-bit window from low and high fields
// (RULE11) mode bit: fixed or automatic touch frequency
// (RULE12) fine tune only in fixed mode, reset 100
// (RULE13) start bit begins, hardware or software clears
// (RULE14) window counts reference cycles, data counts touch
// (RULE15) firmware clears power-down before starting
// (RULE16) each start clears both counters first
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
module tks_scan_ctrl
  import tks_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // oscillator levels from the analogue front end
  input wire logic reference_osc,
  input wire logic touch_osc,
  // analogue front-end controls
  output logic [TKS_KEYS-1:0] key_connect,
  output logic [TKS_TRIM_W-1:0] osc_cap_trim,
  output logic [TKS_FINE_W-1:0] touch_freq_sel,
  output logic freq_auto_change,
  output logic touch_power_down,
  output logic osc_run,
  // status toward the interrupt controller
  output logic touch_irq_flag
);

  // ****************************************************************
  // oscillator synchronisation and edge detection
  // ****************************************************************
  logic ref_osc_s;
  logic touch_osc_s;
  logic ref_osc_d_reg;
  logic ref_osc_d_next;
  logic touch_osc_d_reg;
  logic touch_osc_d_next;
  logic ref_edge;
  logic touch_edge;

  tks_sync u_ref_sync (
    .clk(clk),
    .resetn(resetn),
    .d(reference_osc),
    .q(ref_osc_s)
  );

  tks_sync u_touch_sync (
    .clk(clk),
    .resetn(resetn),
    .d(touch_osc),
    .q(touch_osc_s)
  );

  always_comb begin
    ref_osc_d_next = ref_osc_s;
    touch_osc_d_next = touch_osc_s;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ref_osc_d_reg <= 1'b0;
      touch_osc_d_reg <= 1'b0;
    end else begin
      ref_osc_d_reg <= ref_osc_d_next;
      touch_osc_d_reg <= touch_osc_d_next;
    end
  end

  assign ref_edge = ref_osc_s & ~ref_osc_d_reg;
  assign touch_edge = touch_osc_s & ~touch_osc_d_reg;

  // ****************************************************************
  // register state
  // ****************************************************************
  tks_state_e state_reg;
  tks_state_e state_next;
  logic irq_reg;
  logic irq_next;
  logic start_reg;
  logic start_next;
  logic eoc_reg;
  logic eoc_next;
  logic pd_reg;
  logic pd_next;
  logic [TKS_CHAN_W-1:0] chan_reg;
  logic [TKS_CHAN_W-1:0] chan_next;
  logic [TKS_TRIM_W-1:0] trim_reg;
  logic [TKS_TRIM_W-1:0] trim_next;
  logic [7:0] winl_reg;
  logic [7:0] winl_next;
  logic [TKS_WINH_W-1:0] winh_reg;
  logic [TKS_WINH_W-1:0] winh_next;
  logic auto_reg;
  logic auto_next;
  logic [TKS_FINE_W-1:0] fine_reg;
  logic [TKS_FINE_W-1:0] fine_next;
  logic hop_reg;
  logic hop_next;
  logic [TKS_COUNT_W-1:0] result_reg;
  logic [TKS_COUNT_W-1:0] result_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // ****************************************************************
  // decode and sequencer events
  // ****************************************************************
  logic wr_irq;
  logic wr_trim;
  logic wr_ctrl;
  logic wr_winl;
  logic wr_ctrl2;
  logic wr_aux_control_one;
  logic start_req;
  logic start_accept;
  logic conv_end;
  logic abort;
  logic [TKS_WINDOW_W:0] ref_count;
  logic [TKS_COUNT_W-1:0] data_count;
  logic [TKS_WINDOW_W-1:0] window_length;
  assign wr_irq = reg_wr && (reg_addr == TKS_OFS_IRQ_FLAGS);
  assign wr_trim = reg_wr && (reg_addr == TKS_OFS_OSC_TRIM);
  assign wr_ctrl = reg_wr && (reg_addr == TKS_OFS_CONTROL);
  assign wr_winl = reg_wr && (reg_addr == TKS_OFS_WINDOW_LOW);
  assign wr_ctrl2 = reg_wr && (reg_addr == TKS_OFS_CONTROL2);
  assign wr_aux_control_one = reg_wr && (reg_addr == TKS_OFS_AUX_CONTROL_ONE);
  assign window_length = {winh_reg, winl_reg}; // RULE10
  // a start while powered down is dropped rather than left pending
  assign start_req = wr_aux_control_one && reg_wdata[TKS_START_BIT];
  assign start_accept = start_req && !pd_reg; // RULE13
  // powering down mid-window abandons the conversion, end flag stays low
  assign abort = (state_reg == TKS_RUN) && pd_reg && !start_accept; // RULE6
  assign conv_end = (state_reg == TKS_RUN) && !pd_reg && !start_accept &&
                    (ref_count == {1'b0, window_length}); // RULE14

  // ****************************************************************
  // counters: reference sets the window, data measures the key
  // ****************************************************************
  tks_counter #(
    .W(TKS_WINDOW_W + 1)
  ) u_ref_counter (
    .clk(clk),
    .resetn(resetn),
    .clear(start_accept), // RULE16
    .inc(ref_edge && (state_reg == TKS_RUN)), // RULE14
    .count(ref_count)
  );

  tks_counter #(
    .W(TKS_COUNT_W)
  ) u_data_counter (
    .clk(clk),
    .resetn(resetn),
    .clear(start_accept), // RULE16
    .inc(touch_edge && (state_reg == TKS_RUN)), // RULE14
    .count(data_count)
  );

  // ****************************************************************
  // sequencer and flags
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      TKS_IDLE: begin
        if (start_accept) begin
          state_next = TKS_RUN;
        end
      end
      TKS_RUN: begin
        if (conv_end || abort) begin
          state_next = TKS_IDLE;
        end
      end
      default: begin
        state_next = TKS_IDLE;
      end
    endcase
  end

  always_comb begin
    // set wins over any clear in the same cycle
    irq_next = irq_reg;
    if (conv_end) begin
      irq_next = 1'b1; // RULE1
    end else if ((wr_irq && (reg_wdata == TKS_IRQ_CLEAR_CODE)) || start_accept) begin
      irq_next = 1'b0; // RULE2
    end
    start_next = start_reg;
    if (start_accept) begin
      start_next = 1'b1; // RULE13
    end else if (conv_end || abort || wr_aux_control_one) begin
      start_next = 1'b0; // RULE13
    end
    eoc_next = eoc_reg;
    if (start_accept) begin
      eoc_next = 1'b0; // RULE7
    end else if (conv_end) begin
      eoc_next = 1'b1; // RULE7
    end
    result_next = result_reg;
    if (conv_end) begin
      result_next = data_count; // RULE3
    end
    // auto mode hops between the slow and fast clock after each completed window
    hop_next = hop_reg;
    if (conv_end && auto_reg) begin
      hop_next = ~hop_reg; // RULE11
    end
  end

  // ****************************************************************
  // software-written fields
  // ****************************************************************
  always_comb begin
    pd_next = pd_reg;
    chan_next = chan_reg;
    trim_next = trim_reg;
    winl_next = winl_reg;
    winh_next = winh_reg;
    auto_next = auto_reg;
    fine_next = fine_reg;
    if (wr_ctrl) begin
      pd_next = reg_wdata[TKS_PD_BIT]; // RULE6
      chan_next = reg_wdata[TKS_CHAN_W-1:0]; // RULE9
    end
    if (wr_trim) begin
      trim_next = reg_wdata[TKS_TRIM_W-1:0]; // RULE4
    end
    if (wr_winl) begin
      winl_next = reg_wdata; // RULE10
    end
    if (wr_ctrl2) begin
      auto_next = reg_wdata[TKS_AUTO_BIT]; // RULE11
      fine_next = reg_wdata[TKS_FINE_LSB +: TKS_FINE_W]; // RULE12
      winh_next = reg_wdata[TKS_WINH_W-1:0]; // RULE10
    end
  end

  // ****************************************************************
  // read port: data stand only in the cycle after the strobe
  // ****************************************************************
  always_comb begin
    rdata_next = 8'h00;
    if (reg_rd) begin
      if (reg_addr == TKS_OFS_IRQ_FLAGS) begin
        rdata_next[TKS_IRQ_FLAG_BIT] = irq_reg;
      end else if (reg_addr == TKS_OFS_SHARED_DATA) begin
        rdata_next[3:0] = result_reg[TKS_COUNT_W-1:8]; // RULE3
      end else if (reg_addr == TKS_OFS_COUNT_LOW) begin
        rdata_next = result_reg[7:0]; // RULE3
      end else if (reg_addr == TKS_OFS_OSC_TRIM) begin
        rdata_next[TKS_TRIM_W-1:0] = trim_reg;
      end else if (reg_addr == TKS_OFS_CONTROL) begin
        rdata_next[TKS_PD_BIT] = pd_reg;
        rdata_next[TKS_EOC_BIT] = eoc_reg; // RULE7
        rdata_next[TKS_CHAN_W-1:0] = chan_reg;
      end else if (reg_addr == TKS_OFS_WINDOW_LOW) begin
        rdata_next = winl_reg;
      end else if (reg_addr == TKS_OFS_CONTROL2) begin
        rdata_next[TKS_AUTO_BIT] = auto_reg;
        rdata_next[TKS_FINE_LSB +: TKS_FINE_W] = fine_reg;
        rdata_next[TKS_WINH_W-1:0] = winh_reg;
      end else if (reg_addr == TKS_OFS_AUX_CONTROL_ONE) begin
        rdata_next[TKS_START_BIT] = start_reg;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg <= TKS_IDLE;
      irq_reg <= 1'b0;
      start_reg <= 1'b0;
      eoc_reg <= 1'b0;
      pd_reg <= TKS_PD_RST;
      chan_reg <= TKS_CHAN_RST;
      trim_reg <= TKS_TRIM_RST;
      winl_reg <= TKS_WINL_RST;
      winh_reg <= TKS_WINH_RST;
      auto_reg <= 1'b0;
      fine_reg <= TKS_FINE_RST;
      hop_reg <= 1'b0;
      result_reg <= '0;
      rdata_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      irq_reg <= irq_next;
      start_reg <= start_next;
      eoc_reg <= eoc_next;
      pd_reg <= pd_next;
      chan_reg <= chan_next;
      trim_reg <= trim_next;
      winl_reg <= winl_next;
      winh_reg <= winh_next;
      auto_reg <= auto_next;
      fine_reg <= fine_next;
      hop_reg <= hop_next;
      result_reg <= result_next;
      rdata_reg <= rdata_next;
    end
  end

  // ****************************************************************
  // front-end controls
  // ****************************************************************
  // one-hot pin connect; all keys released while powered down
  assign key_connect = pd_reg ? '0 : (TKS_KEYS'(1) << chan_reg); // RULE9

  // in fixed mode codes 001..110 are passed through untouched; their effect is undefined
  assign touch_freq_sel = auto_reg ? (hop_reg ? TKS_FINE_FAST : TKS_FINE_SLOW) : fine_reg; // RULE12
  assign osc_cap_trim = trim_reg; // RULE4
  assign freq_auto_change = auto_reg;
  assign touch_power_down = pd_reg;
  assign osc_run = (state_reg == TKS_RUN);
  assign touch_irq_flag = irq_reg;
  assign reg_rdata = rdata_reg;

endmodule : tks_scan_ctrl

// >>> rtl/tks_sync.sv
// two-flop synchroniser for an oscillator or pin level
// assumes d is asynchronous to clk; only the second flop is read outside
`timescale 1ns/10ps
module tks_sync (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // level in and out
  input wire logic d,
  output logic q
);

  logic meta_reg;
  logic meta_next;
  logic q_reg;
  logic q_next;

  always_comb begin
    meta_next = d;
    q_next = meta_reg;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta_reg <= 1'b0;
      q_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      q_reg <= q_next;
    end
  end

  assign q = q_reg;

endmodule : tks_sync

// >>> verif/test_tks_scan_ctrl.sv
// self-checking bench for the touch scan control: registers, conversions, flags
// assumes the key model stands in for the analogue front end
`timescale 1ns/10ps
module test_tks_scan_ctrl
  import tks_pkg::*;
;
  localparam int REF_HALF = 150;
  localparam int TOUCH_HALF = 83;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic reference_osc;
  logic touch_osc;
  logic [TKS_KEYS-1:0] key_connect;
  logic [TKS_TRIM_W-1:0] osc_cap_trim;
  logic [TKS_FINE_W-1:0] touch_freq_sel;
  logic freq_auto_change;
  logic touch_power_down;
  logic osc_run;
  logic touch_irq_flag;
  int error_cnt = 0;
  int checks_done = 0;
  logic [7:0] rv;
  logic [7:0] ra [9] = '{8'h95, 8'hAA, 8'hAC, 8'hAD, 8'hAE, 8'hB4, 8'hB5, 8'hF8, 8'h10};
  logic [7:0] re [9] = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h8F, 8'hFF, 8'h40, 8'h00, 8'h00};

  always #12.5 clk = ~clk;

  tks_scan_ctrl dut (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reference_osc,
    .touch_osc, .key_connect, .osc_cap_trim, .touch_freq_sel, .freq_auto_change, .touch_power_down, .osc_run,
    .touch_irq_flag);
  tks_key_model #(.REF_HALF_NS(REF_HALF), .TOUCH_HALF_NS(TOUCH_HALF)) u_keys (.touch_power_down,
    .reference_osc, .touch_osc);

  // ****************************************************************
  // bus and compare tasks
  // ****************************************************************
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_in(input string what, input int lo, input int hi, input logic [11:0] got);
    checks_done++;
    if ($isunknown(got) || int'(got) < lo || int'(got) > hi) begin
      error_cnt++;
      $display("wrong value %s expected %0d to %0d seen %h", what, lo, hi, got);
    end
  endtask : chk_in

  // the trailing 1 ns lets the design's updates from the taking edge land
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic rc(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(what, {8'h00, exp}, {8'h00, d});
  endtask : rc

  // polls the end flag; software may not trust it before the lag has passed
  task automatic finish(input logic [11:0] w);
    int n;
    int e;
    logic [7:0] hi;
    n = 0;
    repeat (TKS_EOC_LAG_CYC) @(posedge clk);
    do begin
      rd(TKS_OFS_CONTROL, rv);
      n++;
    end while (rv[TKS_EOC_BIT] !== 1'b1 && n < 4000);
    if (n >= 4000) begin
      error_cnt++;
      $display("wrong value end flag expected 1 seen %h", rv);
      tally_and_finish();
    end
    chk("irq flag", 16'h0001, 16'(touch_irq_flag));
    rc("start bit after end", TKS_OFS_AUX_CONTROL_ONE, 8'h00);
    rc("flag register", TKS_OFS_IRQ_FLAGS, 8'h20);
    rd(TKS_OFS_SHARED_DATA, hi);
    rd(TKS_OFS_COUNT_LOW, rv);
    e = int'(w) * REF_HALF / TOUCH_HALF;
    chk_in("count", (e > 4) ? e - 4 : 0, e + 3, {hi[3:0], rv});
  endtask : finish

  task automatic convert(input logic [11:0] w);
    wr(TKS_OFS_WINDOW_LOW, w[7:0]);
    wr(TKS_OFS_CONTROL2, {4'h0, w[11:8]});
    wr(TKS_OFS_AUX_CONTROL_ONE, 8'h20);
    chk("run at start", 16'h0001, 16'(osc_run));
    chk("irq at start", 16'h0000, 16'(touch_irq_flag));
    finish(w);
  endtask : convert

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    foreach (ra[i]) rc("reset read", ra[i], re[i]);
    chk("keys at reset", 16'h0000, key_connect);
    chk("trim at reset", 16'h0040, 16'(osc_cap_trim));
    chk("fine at reset", 16'h0004, 16'(touch_freq_sel));
    wr(TKS_OFS_OSC_TRIM, 8'hFF);
    rc("trim", TKS_OFS_OSC_TRIM, 8'h7F);
    chk("trim out", 16'h007F, 16'(osc_cap_trim));
    wr(TKS_OFS_SHARED_DATA, 8'hFF);
    rc("read-only data", TKS_OFS_SHARED_DATA, 8'h00);
    wr(TKS_OFS_CONTROL2, 8'h70);
    chk("fine fast", 16'h0007, 16'(touch_freq_sel));
    wr(TKS_OFS_CONTROL2, 8'hF0);
    chk("auto mode", 16'h0001, 16'(freq_auto_change));
    chk("auto overrides fine", 16'h0000, 16'(touch_freq_sel));
    rc("control2", TKS_OFS_CONTROL2, 8'hF0);
    wr(TKS_OFS_AUX_CONTROL_ONE, 8'h20);
    chk("start while off", 16'h0000, 16'(osc_run));
    rc("start bit while off", TKS_OFS_AUX_CONTROL_ONE, 8'h00);
    for (int ch = 15; ch >= 0; ch--) begin
      wr(TKS_OFS_CONTROL, 8'(ch));
      chk("key select", 16'h0001 << ch, key_connect);
    end
    wr(TKS_OFS_OSC_TRIM, 8'h40);
    wr(TKS_OFS_IRQ_FLAGS, 8'hDF);
    convert(12'h010);
    convert(12'h100);
    convert(12'h004);
    convert(12'h000);
    wr(TKS_OFS_IRQ_FLAGS, 8'hDE);
    rc("flag after wrong code", TKS_OFS_IRQ_FLAGS, 8'h20);
    wr(TKS_OFS_IRQ_FLAGS, 8'hDF);
    rc("flag after clear", TKS_OFS_IRQ_FLAGS, 8'h00);
    convert(12'h010);
    wr(TKS_OFS_AUX_CONTROL_ONE, 8'h20);
    chk("irq at restart", 16'h0000, 16'(touch_irq_flag));
    wr(TKS_OFS_AUX_CONTROL_ONE, 8'h00);
    chk("run after soft clear", 16'h0001, 16'(osc_run));
    rc("start bit soft clear", TKS_OFS_AUX_CONTROL_ONE, 8'h00);
    finish(12'h010);
    wr(TKS_OFS_WINDOW_LOW, 8'hFF);
    wr(TKS_OFS_AUX_CONTROL_ONE, 8'h20);
    repeat (20) @(posedge clk);
    wr(TKS_OFS_CONTROL, 8'h80);
    // the sequencer sees the power-down bit one edge after it is written
    @(posedge clk);
    #1;
    chk("power down out", 16'h0001, 16'(touch_power_down));
    chk("run after abort", 16'h0000, 16'(osc_run));
    chk("irq after abort", 16'h0000, 16'(touch_irq_flag));
    rc("end flag after abort", TKS_OFS_CONTROL, 8'h80);
    tally_and_finish();
  end
endmodule : test_tks_scan_ctrl

// >>> verif/tks_key_model.sv
// touch electrode with its reference and touch oscillators
// assumes the oscillators run only while the touch module is powered up
`timescale 1ns/10ps
module tks_key_model #(
  parameter int REF_HALF_NS = 150,
  parameter int TOUCH_HALF_NS = 83
) (
  // power control
  input wire logic touch_power_down,
  // oscillator levels
  output logic reference_osc,
  output logic touch_osc
);
  // ****************************************************************
  // oscillators
  // ****************************************************************
  // a stopped oscillator rests low; the 3 ns offset keeps the reference edges off the clock edges
  always begin
    reference_osc = 1'b0;
    wait (touch_power_down === 1'b0);
    #3;
    while (touch_power_down === 1'b0) begin
      #(REF_HALF_NS) reference_osc = ~reference_osc;
    end
  end

  // trim assumed set so that count is near 1.81 times the window
  always begin
    touch_osc = 1'b0;
    wait (touch_power_down === 1'b0);
    #3;
    while (touch_power_down === 1'b0) begin
      #(TOUCH_HALF_NS) touch_osc = ~touch_osc;
    end
  end
endmodule : tks_key_model

// >>> verif/tks_scan_ctrl_asserts.sv
// checker for the touch scan control: start, end, flag and key-select relations
// assumes it is bound into tks_scan_ctrl and sees only that module's ports
`timescale 1ns/10ps
module tks_scan_ctrl_asserts
  import tks_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // front end and status
  input wire logic [TKS_KEYS-1:0] key_connect,
  input wire logic [TKS_TRIM_W-1:0] osc_cap_trim,
  input wire logic [TKS_FINE_W-1:0] touch_freq_sel,
  input wire logic freq_auto_change,
  input wire logic touch_power_down,
  input wire logic osc_run,
  input wire logic touch_irq_flag
);
  // ****************************************************************
  // relations
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic go_wr;
  logic clr_wr;
  logic go_refused;
  assign go_wr = reg_wr && reg_addr == TKS_OFS_AUX_CONTROL_ONE && reg_wdata[TKS_START_BIT] && !touch_power_down;
  assign go_refused = reg_wr && reg_addr == TKS_OFS_AUX_CONTROL_ONE && reg_wdata[TKS_START_BIT] && touch_power_down;
  assign clr_wr = reg_wr && reg_addr == TKS_OFS_IRQ_FLAGS && reg_wdata == TKS_IRQ_CLEAR_CODE;

  a_start_runs: assert property (go_wr |=> osc_run && !touch_irq_flag)
    else $error("start did not launch a clean conversion");
  a_pd_refuse: assert property (go_refused && !osc_run |=> !osc_run)
    else $error("start accepted while powered down");
  a_end_irq: assert property ($fell(osc_run) && !touch_power_down |-> touch_irq_flag)
    else $error("conversion end without touch flag");
  a_irq_cause: assert property ($rose(touch_irq_flag) |-> $fell(osc_run))
    else $error("touch flag rose outside a conversion end");
  a_irq_clear: assert property (clr_wr && !osc_run |=> !touch_irq_flag)
    else $error("clear code left the touch flag set");
  a_irq_hold: assert property (touch_irq_flag && !clr_wr && !go_wr |=> touch_irq_flag)
    else $error("touch flag dropped without cause");
  a_key_off: assert property (touch_power_down |-> key_connect == '0)
    else $error("key connected while powered down");
  a_key_onehot: assert property (!touch_power_down |-> $onehot(key_connect))
    else $error("key select not one-hot");
  a_trim_wr: assert property (reg_wr && reg_addr == TKS_OFS_OSC_TRIM |=> osc_cap_trim == $past(reg_wdata[6:0]))
    else $error("trim write not applied");
  a_fine_wr: assert property (reg_wr && reg_addr == TKS_OFS_CONTROL2 && !reg_wdata[7]
    |=> !freq_auto_change && touch_freq_sel == $past(reg_wdata[6:4]))
    else $error("fixed fine tune not applied");
  a_rd_quiet: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside the answer cycle");

  c_start: cover property (go_wr);
  c_end: cover property ($fell(osc_run) && touch_irq_flag);
  c_abort: cover property ($fell(osc_run) && touch_power_down);
endmodule : tks_scan_ctrl_asserts

bind tks_scan_ctrl tks_scan_ctrl_asserts u_asserts (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .key_connect, .osc_cap_trim, .touch_freq_sel, .freq_auto_change, .touch_power_down, .osc_run,
  .touch_irq_flag);
